// ==== cas_pkg.sv ====
// package for the per-channel alarm status and change-latch block
package cas_pkg;

  // ------------------------------------------------------------
  // geometry and register map
  // ------------------------------------------------------------
  localparam int          CAS_NUM_CH      = 8;
  localparam int          CAS_ADDR_W      = 8;
  localparam logic [7:0]  CAS_OFF_ENABLE  = 8'h04;  // per channel enables
  localparam logic [7:0]  CAS_OFF_LIVE    = 8'h05;  // live status, read only
  localparam logic [7:0]  CAS_OFF_CHANGE  = 8'h06;  // change latch, clear on read
  localparam logic [7:0]  CAS_CH_STRIDE   = 8'h10;
  localparam logic [7:0]  CAS_OFF_GLOBAL0 = 8'h80;  // global irq enable
  localparam logic [7:0]  CAS_OFF_GLOBAL1 = 8'h81;  // overflow select

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CAS_B_PATTERN  = 0;
  localparam int CAS_B_LOSS     = 1;
  localparam int CAS_B_ALL_ONES = 2;
  localparam int CAS_B_CODE_ERR = 4;
  localparam int CAS_B_FIFO_LIM = 5;
  localparam int CAS_B_DRV_MON  = 6;
  localparam int CAS_B_GIE      = 0;
  localparam int CAS_B_OVF_SEL  = 7;
  localparam logic [7:0] CAS_USED_MASK  = 8'h77;  // D7 and D3 read zero
  localparam logic [7:0] CAS_RESET_BYTE = 8'h00;

  // raw detector levels for one channel
  typedef struct packed {
    logic drv_fail;
    logic fifo_near;
    logic code_viol;
    logic cnt_ovf;
    logic all_ones;
    logic sig_loss;
    logic prbs_match;
  } cas_det_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cas_req_t;

endpackage : cas_pkg

// ==== cas_alarm_irq.sv ====
// per-channel alarm status, change latch and interrupt gating, eight channels
//
// Contract
// R1: by default live bit D4 follows line code violation activity
// R2: overflow select bit 7 of 0x81 makes D4 follow counter overflow
// R3: violation mode D4 is one on violation, bipolar violation or excess zeros
// R4: live bit D2 shows all-ones detection regardless of interrupt enable
// R5: live bit D1 shows loss of signal regardless of interrupt enable
// R6: live bit D0 shows pattern match regardless of interrupt enable
// R7: code error interrupt needs channel enable D4 and global enable
// R8: all-ones interrupt needs channel enable D2 and global enable
// R9: signal loss interrupt needs channel enable D1 and global enable
// R10: pattern interrupt needs channel enable D0 and global enable
// R11: change bit D6 latches on driver monitor status change
// R12: change bit D5 latches on fifo limit status change
// R13: change bit D4 latches on code error status change
// R14: change bit D2 latches on all-ones status change
// R15: change bit D1 latches on signal loss status change
// R16: change bit D0 latches on pattern match status change
// R17: every latched change interrupts when channel and global enabled
// R18: reading the change register clears its bits
// R19: fifo limit bit is one while fifo pointers are within three
// R20: driver monitor bit is one while the driver has failed
// R21: a zero enable bit masks that source, a one permits it
// R22: registers repeat for eight channels at stride 0x10
// R23: D3 and D7 read zero, change bits zero after reset
// R24: interrupt output high while any enabled change bit is set and global on
`timescale 1ns/100ps
`default_nettype none

module cas_alarm_irq
  import cas_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_sys_rst,
  input  wire cas_det_t [CAS_NUM_CH-1:0] i_det,
  input  wire cas_req_t                 i_req,
  output logic [7:0]                    o_rdata,
  output logic                          o_irq
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // channel address: low nibble is offset, high nibble channel
  function automatic logic hit_ch(input logic [7:0] a, input logic [7:0] off, input int ch);
    hit_ch = (a == 8'((off + CAS_CH_STRIDE * ch)));
  endfunction : hit_ch

  // ------------------------------------------------------------
  // input synchronisers, detectors come from other domains
  // ------------------------------------------------------------
  cas_det_t [CAS_NUM_CH-1:0] det_s1_ff;
  cas_det_t [CAS_NUM_CH-1:0] det_s2_ff;

  // two stages before any logic looks at detector levels
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      det_s1_ff <= '0;
      det_s2_ff <= '0;
    end else begin
      det_s1_ff <= i_det;
      det_s2_ff <= det_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // global registers
  // ------------------------------------------------------------
  logic global_irq_enable_ff;
  logic ovf_select_ff;

  // global enable and counter overflow select, written by software
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      global_irq_enable_ff <= 1'b0;
      ovf_select_ff        <= 1'b0;
    end else if (i_req.wr) begin
      if (i_req.addr == CAS_OFF_GLOBAL0)
        global_irq_enable_ff <= i_req.wdata[CAS_B_GIE];
      if (i_req.addr == CAS_OFF_GLOBAL1)
        ovf_select_ff <= i_req.wdata[CAS_B_OVF_SEL];
    end
  end

  // ------------------------------------------------------------
  // per channel logic
  // ------------------------------------------------------------
  logic [CAS_NUM_CH-1:0][7:0] enable_ff;
  logic [CAS_NUM_CH-1:0][7:0] live_ff;
  logic [CAS_NUM_CH-1:0][7:0] change_ff;
  logic [CAS_NUM_CH-1:0]      ch_pend;

  genvar g;
  generate
    for (g = 0; g < CAS_NUM_CH; g++) begin : g_ch
      logic [7:0] nxt_live;
      logic [7:0] edge_bits;
      logic       rd_change;

      // live status from synchronised detectors
      always_comb begin
        nxt_live = CAS_RESET_BYTE;
        nxt_live[CAS_B_DRV_MON]  = det_s2_ff[g].drv_fail;   // R20
        nxt_live[CAS_B_FIFO_LIM] = det_s2_ff[g].fifo_near;  // R19
        nxt_live[CAS_B_CODE_ERR] = ovf_select_ff ? det_s2_ff[g].cnt_ovf  // R2
                                                 : det_s2_ff[g].code_viol;  // R1 R3
        nxt_live[CAS_B_ALL_ONES] = det_s2_ff[g].all_ones;    // R4
        nxt_live[CAS_B_LOSS]     = det_s2_ff[g].sig_loss;    // R5
        nxt_live[CAS_B_PATTERN]  = det_s2_ff[g].prbs_match;  // R6
      end

      // any transition of a live bit, unused bits masked
      assign edge_bits = (nxt_live ^ live_ff[g]) & CAS_USED_MASK;  // R11 R12 R13 R14 R15 R16
      assign rd_change = i_req.rd && hit_ch(i_req.addr, CAS_OFF_CHANGE, g);  // R22

      // live register follows the synchronised detectors one cycle later
      always_ff @(posedge i_clock) begin
        if (i_sys_rst)
          live_ff[g] <= CAS_RESET_BYTE;
        else
          live_ff[g] <= nxt_live;
      end

      // change latch: a new edge wins over the read clear
      always_ff @(posedge i_clock) begin
        if (i_sys_rst)
          change_ff[g] <= CAS_RESET_BYTE;  // R23
        else if (rd_change)
          change_ff[g] <= edge_bits;  // R18
        else
          change_ff[g] <= change_ff[g] | edge_bits;  // R11 R12 R13 R14 R15 R16
      end

      // channel interrupt enables
      always_ff @(posedge i_clock) begin
        if (i_sys_rst)
          enable_ff[g] <= CAS_RESET_BYTE;
        else if (i_req.wr && hit_ch(i_req.addr, CAS_OFF_ENABLE, g))
          enable_ff[g] <= i_req.wdata & CAS_USED_MASK;  // R22
      end

      // a zero enable masks its source
      assign ch_pend[g] = |(change_ff[g] & enable_ff[g]);  // R7 R8 R9 R10 R21
    end
  endgenerate

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  // registered so the pin never glitches; one cycle behind the latch
  always_ff @(posedge i_clock) begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= global_irq_enable_ff && (|ch_pend);  // R17 R24
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  logic [7:0] nxt_rdata;

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = CAS_RESET_BYTE;
    if (i_req.addr == CAS_OFF_GLOBAL0)
      nxt_rdata[CAS_B_GIE] = global_irq_enable_ff;
    if (i_req.addr == CAS_OFF_GLOBAL1)
      nxt_rdata[CAS_B_OVF_SEL] = ovf_select_ff;
    for (int c = 0; c < CAS_NUM_CH; c++) begin
      if (hit_ch(i_req.addr, CAS_OFF_ENABLE, c))
        nxt_rdata = enable_ff[c];
      if (hit_ch(i_req.addr, CAS_OFF_LIVE, c))
        nxt_rdata = live_ff[c] & CAS_USED_MASK;  // R23
      if (hit_ch(i_req.addr, CAS_OFF_CHANGE, c))
        nxt_rdata = change_ff[c] & CAS_USED_MASK;  // R23
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (i_sys_rst)
      o_rdata <= CAS_RESET_BYTE;
    else if (i_req.rd)
      o_rdata <= nxt_rdata;
    else
      o_rdata <= CAS_RESET_BYTE;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_irq_needs_gie;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_irq |-> $past(global_irq_enable_ff);
  endproperty
  a_irq_needs_gie: assert property (p_irq_needs_gie)  // R17
    else $error("interrupt raised with global enable low");

  property p_irq_masked;
    @(posedge i_clock) disable iff (i_sys_rst)
      (enable_ff[0] == 8'h00 && enable_ff[1] == 8'h00 && enable_ff == '0) |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)  // R21
    else $error("interrupt raised with all enables zero");

  property p_irq_set;
    @(posedge i_clock) disable iff (i_sys_rst)
      (global_irq_enable_ff && (|ch_pend)) |=> o_irq;
  endproperty
  a_irq_set: assert property (p_irq_set)  // R24
    else $error("interrupt missing for pending enabled change");

  property p_irq_clear;
    @(posedge i_clock) disable iff (i_sys_rst)
      !(global_irq_enable_ff && (|ch_pend)) |=> !o_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear)  // R24
    else $error("interrupt held with nothing pending");

  // read data must be zero outside the answer cycle, so a stale
  // value can never be mistaken for a fresh one
  property p_rdata_idle;
    @(posedge i_clock) disable iff (i_sys_rst)
      !i_req.rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)  // R22
    else $error("read data present without a read strobe");

  // ------------------------------------------------------------
  // per channel checks
  // ------------------------------------------------------------
  // every replica is watched, so a wrong stride or index in one
  // channel cannot hide behind a healthy channel 0
  generate
    for (g = 0; g < CAS_NUM_CH; g++) begin : g_chk
      // read strobe aimed at this channel's change register
      sequence s_clear_read;
        i_req.rd && hit_ch(i_req.addr, CAS_OFF_CHANGE, g);
      endsequence

      // no detector transition lands in the same cycle
      sequence s_no_edge;
        g_ch[g].edge_bits == 8'h00;
      endsequence

      property p_clear_on_read;
        @(posedge i_clock) disable iff (i_sys_rst)
          (s_clear_read ##0 s_no_edge) |=> change_ff[g] == 8'h00;
      endproperty
      a_clear_on_read: assert property (p_clear_on_read)  // R18
        else $error("change latch not cleared by read");

      property p_change_holds;
        @(posedge i_clock) disable iff (i_sys_rst)
          !g_ch[g].rd_change |=> &(change_ff[g] | ~$past(change_ff[g]));
      endproperty
      a_change_holds: assert property (p_change_holds)  // R18
        else $error("latched change lost without a read");

      property p_loss_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_LOSS]) |-> change_ff[g][CAS_B_LOSS];
      endproperty
      a_loss_edge: assert property (p_loss_edge)  // R15
        else $error("signal loss change not latched");

      property p_code_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_CODE_ERR]) |-> change_ff[g][CAS_B_CODE_ERR];
      endproperty
      a_code_edge: assert property (p_code_edge)  // R13
        else $error("code error change not latched");

      property p_all_ones_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_ALL_ONES]) |-> change_ff[g][CAS_B_ALL_ONES];
      endproperty
      a_all_ones_edge: assert property (p_all_ones_edge)  // R14
        else $error("all ones change not latched");

      property p_pattern_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_PATTERN]) |-> change_ff[g][CAS_B_PATTERN];
      endproperty
      a_pattern_edge: assert property (p_pattern_edge)  // R16
        else $error("pattern match change not latched");

      property p_fifo_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_FIFO_LIM]) |-> change_ff[g][CAS_B_FIFO_LIM];
      endproperty
      a_fifo_edge: assert property (p_fifo_edge)  // R12
        else $error("fifo limit change not latched");

      property p_drv_edge;
        @(posedge i_clock) disable iff (i_sys_rst)
          $changed(live_ff[g][CAS_B_DRV_MON]) |-> change_ff[g][CAS_B_DRV_MON];
      endproperty
      a_drv_edge: assert property (p_drv_edge)  // R11
        else $error("driver monitor change not latched");

      property p_all_ones_follow;
        @(posedge i_clock) disable iff (i_sys_rst)
          det_s2_ff[g].all_ones |=> live_ff[g][CAS_B_ALL_ONES];
      endproperty
      a_all_ones_follow: assert property (p_all_ones_follow)  // R4
        else $error("all ones status not following detector");

      property p_loss_follow;
        @(posedge i_clock) disable iff (i_sys_rst)
          live_ff[g][CAS_B_LOSS] == $past(det_s2_ff[g].sig_loss);
      endproperty
      a_loss_follow: assert property (p_loss_follow)  // R5
        else $error("signal loss status not following detector");

      property p_pattern_follow;
        @(posedge i_clock) disable iff (i_sys_rst)
          live_ff[g][CAS_B_PATTERN] == $past(det_s2_ff[g].prbs_match);
      endproperty
      a_pattern_follow: assert property (p_pattern_follow)  // R6
        else $error("pattern status not following detector");

      property p_fifo_follow;
        @(posedge i_clock) disable iff (i_sys_rst)
          live_ff[g][CAS_B_FIFO_LIM] == $past(det_s2_ff[g].fifo_near);
      endproperty
      a_fifo_follow: assert property (p_fifo_follow)  // R19
        else $error("fifo limit status not following detector");

      property p_drv_follow;
        @(posedge i_clock) disable iff (i_sys_rst)
          live_ff[g][CAS_B_DRV_MON] == $past(det_s2_ff[g].drv_fail);
      endproperty
      a_drv_follow: assert property (p_drv_follow)  // R20
        else $error("driver monitor status not following detector");

      property p_ovf_sel;
        @(posedge i_clock) disable iff (i_sys_rst)
          (ovf_select_ff && det_s2_ff[g].cnt_ovf) |=> live_ff[g][CAS_B_CODE_ERR];
      endproperty
      a_ovf_sel: assert property (p_ovf_sel)  // R2
        else $error("overflow select not steering code error bit");

      property p_ovf_clear;
        @(posedge i_clock) disable iff (i_sys_rst)
          (ovf_select_ff && !det_s2_ff[g].cnt_ovf) |=> !live_ff[g][CAS_B_CODE_ERR];
      endproperty
      a_ovf_clear: assert property (p_ovf_clear)  // R2
        else $error("code error bit set without overflow");

      property p_viol_mode;
        @(posedge i_clock) disable iff (i_sys_rst)
          (!ovf_select_ff && !det_s2_ff[g].code_viol) |=> !live_ff[g][CAS_B_CODE_ERR];
      endproperty
      a_viol_mode: assert property (p_viol_mode)  // R1
        else $error("code error bit set without violation");

      property p_viol_set;
        @(posedge i_clock) disable iff (i_sys_rst)
          (!ovf_select_ff && det_s2_ff[g].code_viol) |=> live_ff[g][CAS_B_CODE_ERR];
      endproperty
      a_viol_set: assert property (p_viol_set)  // R3
        else $error("code error bit missing on violation");

      property p_unused_zero;
        @(posedge i_clock) disable iff (i_sys_rst)
          ((live_ff[g] | change_ff[g] | enable_ff[g]) & ~CAS_USED_MASK) == 8'h00;
      endproperty
      a_unused_zero: assert property (p_unused_zero)  // R23
        else $error("unused bit D3 or D7 set in a channel register");

      property p_enable_write;
        @(posedge i_clock) disable iff (i_sys_rst)
          (i_req.wr && hit_ch(i_req.addr, CAS_OFF_ENABLE, g))
            |=> enable_ff[g] == ($past(i_req.wdata) & CAS_USED_MASK);
      endproperty
      a_enable_write: assert property (p_enable_write)  // R22
        else $error("channel enable write not taken");
    end
  endgenerate

  property p_reserved_zero;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_req.rd |=> (o_rdata[3] == 1'b0 || $past(i_req.addr) >= CAS_OFF_GLOBAL0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)  // R23
    else $error("reserved bit D3 read as one");

endmodule : cas_alarm_irq

`default_nettype wire

// ==== cas_tb.sv ====
// self-checking bench for the alarm status and change-latch block
`timescale 1ns/100ps
`default_nettype none

module tb;
  import cas_pkg::*;

  // ----------------------------------------
  // clock, stimulus and counters
  // ----------------------------------------
  logic                          i_clock = 1'b0;
  logic                          i_sys_rst = 1'b1;
  cas_det_t [CAS_NUM_CH-1:0]     det = '0;
  cas_req_t                      req = '0;
  logic [7:0]                    rdata;
  logic                          irq;
  int                            fails = 0;
  int                            checked = 0;
  int                            cyc = 0;
  logic [7:0]                    got;
  logic [7:0]                    bm;

  always #2.5 i_clock = ~i_clock;

  cas_alarm_irq cas_alarm_irq_inst (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_det     (det),
    .i_req     (req),
    .o_rdata   (rdata),
    .o_irq     (irq)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t data %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic e);
    #1;  // irq moves on the edge itself; look once it has settled
    checked++;
    if (irq !== e) begin
      fails++;
      $display("BAD %0t irq %b expected %b", $time, irq, e);
    end
  endtask : chk1

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
  endtask : settle

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    req.wr <= 1'b0;
  endtask : wr

  // read data land in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    req.rd <= 1'b0;
    #1 got = rdata;
    chk8(got, e);
  endtask : rd

  function automatic logic [7:0] ad(input int ch, input logic [7:0] off);
    return CAS_CH_STRIDE * 8'(ch) + off;
  endfunction : ad

  // drive one detector by its register bit position
  task automatic put(input int ch, input int b, input logic v);
    @(posedge i_clock);
    case (b)
      0: det[ch].prbs_match <= v;
      1: det[ch].sig_loss <= v;
      2: det[ch].all_ones <= v;
      4: det[ch].code_viol <= v;
      5: det[ch].fifo_near <= v;
      default: det[ch].drv_fail <= v;
    endcase
  endtask : put

  // hang guard, the whole run needs about five hundred cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    settle(20);
    i_sys_rst <= 1'b0;
    rd(ad(0, CAS_OFF_CHANGE), 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(ad(2, CAS_OFF_ENABLE), 8'hFF);
    rd(ad(2, CAS_OFF_ENABLE), 8'h77);
    wr(ad(2, CAS_OFF_ENABLE), 8'h00);
    // every channel, every detector but counter overflow, no enables set
    for (int ch = 0; ch < CAS_NUM_CH; ch++) begin
      @(posedge i_clock);
      det[ch] <= 7'b1110111;
      settle(6);
      chk1(1'b0);
      rd(ad(ch, CAS_OFF_LIVE), 8'h77);
      rd(ad(ch, CAS_OFF_CHANGE), 8'h77);
      rd(ad(ch, CAS_OFF_CHANGE), 8'h00);
      @(posedge i_clock);
      det[ch] <= '0;
      settle(6);
      rd(ad(ch, CAS_OFF_LIVE), 8'h00);
      rd(ad(ch, CAS_OFF_CHANGE), 8'h77);
    end
    // overflow select swaps the source of the code error bit
    wr(CAS_OFF_GLOBAL1, 8'h80);
    rd(CAS_OFF_GLOBAL1, 8'h80);
    @(posedge i_clock);
    det[1].cnt_ovf <= 1'b1;
    settle(6);
    rd(ad(1, CAS_OFF_LIVE), 8'h10);
    @(posedge i_clock);
    det[1] <= 7'b0010000;
    settle(6);
    rd(ad(1, CAS_OFF_LIVE), 8'h00);
    wr(CAS_OFF_GLOBAL1, 8'h00);
    settle(6);
    rd(ad(1, CAS_OFF_LIVE), 8'h10);
    @(posedge i_clock);
    det[1] <= '0;
    settle(6);
    rd(ad(1, CAS_OFF_CHANGE), 8'h10);
    // per-source interrupt gating, each source on its own channel
    for (int b = 0; b < 7; b++) begin
      if (b == 3) continue;
      bm = 8'h01 << b;
      wr(ad(b, CAS_OFF_ENABLE), ~bm & 8'h77);
      wr(CAS_OFF_GLOBAL0, 8'h01);
      rd(CAS_OFF_GLOBAL0, 8'h01);
      put(b, b, 1'b1);
      settle(6);
      chk1(1'b0);
      rd(ad(b, CAS_OFF_CHANGE), bm);
      wr(CAS_OFF_GLOBAL0, 8'h00);
      wr(ad(b, CAS_OFF_ENABLE), bm);
      put(b, b, 1'b0);
      settle(6);
      chk1(1'b0);
      wr(CAS_OFF_GLOBAL0, 8'h01);
      settle(3);
      chk1(1'b1);
      rd(ad(b, CAS_OFF_CHANGE), bm);
      settle(3);
      chk1(1'b0);
      wr(ad(b, CAS_OFF_ENABLE), 8'h00);
    end
    results();
  end

endmodule : tb

`default_nettype wire
